// >>> src/frc_pkg.sv
// Package for the fast RC trim and clock output block
package frc_pkg;
  // I/O space index of each register (arbitrary placement)
  localparam logic [5:0] FRC_ADDR_TRIM = 6'h26;
  localparam logic [5:0] FRC_ADDR_MCU = 6'h35;
  // Trim field layout
  localparam int FRC_RANGE_MSB = 7;
  localparam int FRC_RANGE_LSB = 5;
  localparam int FRC_TUNE_MSB = 4;
  localparam int FRC_TUNE_LSB = 0;
  // Clock output enable position in the MCU control register
  localparam int FRC_CKOUT_BIT = 5;
  localparam logic [7:0] FRC_MCU_RST = 8'h00;
  // Write mask of the MCU control register: only the clock-out bit is held here
  localparam logic [7:0] FRC_MCU_WMASK = 8'h20;
  // Reset trim held until the factory load (arbitrary neutral value)
  localparam logic [7:0] FRC_TRIM_DEFAULT = 8'h80;

  typedef struct packed {
    logic [2:0] range;
    logic [4:0] tune;
  } frc_trim_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } frc_io_req_s;
endpackage

// >>> src/frc_trim_clkout.sv
// Fast RC oscillator trim register and divided clock output
// Behaviour
// - During reset the trim register holds the neutral default; the factory calibration value loads on the first enabled edge after release.
// - Software can rewrite the trim register on any enabled edge except the factory load edge, which wins, and the oscillator follows the new value.
// - The upper three trim bits select the frequency range, all zeros lowest and all ones highest.
// - Adjacent ranges overlap, so the trim code is not monotonic across range boundaries.
// - The lower five trim bits tune within the range, zero lowest and all ones highest.
// - Setting the clock-out enable bit drives the CPU clock divided by two onto port B bit two.
// - The clock output is only available outside serial programming mode, where the pin is data out.
`timescale 1ns/100ps
`default_nettype none
module frc_trim_clkout
  import frc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire frc_io_req_s io_req,
  input wire logic [7:0] factory_trim,
  input wire logic prog_mode,
  input wire logic prog_data_out,
  input wire logic port_b_bit_two_out,
  input wire logic port_b_bit_two_oe,
  output logic [7:0] io_rdata,
  output frc_trim_s osc_trim_value,
  output logic clk_out_enable,
  output logic port_b_bit_two_o,
  output logic port_b_bit_two_en
);

  // Register state: trim, clock-out control, the one-shot factory load, read data and the divider
  logic [7:0] trim_r, trim_nxt;
  logic [7:0] mcu_r, mcu_nxt;
  logic load_r, load_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic div_r, div_nxt;
  // Decoded strobes, shared by the next-state logic and the checks
  logic wr_trim, wr_mcu, rd_trim, rd_mcu;

  function automatic logic hit(input frc_io_req_s r, input logic [5:0] a);
    return r.addr == a;
  endfunction

  assign wr_trim = io_req.wr && hit(io_req, FRC_ADDR_TRIM);
  assign wr_mcu = io_req.wr && hit(io_req, FRC_ADDR_MCU);
  assign rd_trim = io_req.rd && hit(io_req, FRC_ADDR_TRIM);
  assign rd_mcu = io_req.rd && hit(io_req, FRC_ADDR_MCU);

  always_comb begin
    trim_nxt = trim_r;
    mcu_nxt = mcu_r;
    load_nxt = 1'b0;
    // Factory value is a port, so it is caught on the first enabled edge after release
    if (load_r) begin
      trim_nxt = factory_trim;
    end else if (wr_trim) begin
      trim_nxt = io_req.wdata;
    end
    // Only the clock-out bit is held here
    if (wr_mcu) begin
      mcu_nxt = io_req.wdata & FRC_MCU_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_r <= FRC_TRIM_DEFAULT;
      mcu_r <= FRC_MCU_RST;
      load_r <= 1'b1;
    end else if (clk_en) begin
      trim_r <= trim_nxt;
      mcu_r <= mcu_nxt;
      load_r <= load_nxt;
    end
  end

  // Unmapped addresses read as zero; a read beside a write sees the old value
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_trim) begin
      rdata_nxt = trim_r;
    end else if (rd_mcu) begin
      rdata_nxt = mcu_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Toggle only while enabled so the output starts from a known phase
  always_comb begin
    div_nxt = 1'b0;
    if (mcu_r[FRC_CKOUT_BIT] && !prog_mode) begin
      div_nxt = ~div_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 1'b0;
    end else if (clk_en) begin
      div_r <= div_nxt;
    end
  end

  // Range and tune go straight to the analog trim; overlap is the oscillator's own
  always_comb begin
    osc_trim_value.range = trim_r[FRC_RANGE_MSB:FRC_RANGE_LSB];
    osc_trim_value.tune = trim_r[FRC_TUNE_MSB:FRC_TUNE_LSB];
  end
  assign io_rdata = rdata_r;
  assign clk_out_enable = mcu_r[FRC_CKOUT_BIT];

  // Programming data out overrides everything on the shared pin
  always_comb begin
    if (prog_mode) begin
      port_b_bit_two_o = prog_data_out;
      port_b_bit_two_en = 1'b1;
    end else if (clk_out_enable) begin
      port_b_bit_two_o = div_r;
      port_b_bit_two_en = 1'b1;
    end else begin
      port_b_bit_two_o = port_b_bit_two_out;
      port_b_bit_two_en = port_b_bit_two_oe;
    end
  end

  // Register checks
  a_factory_load: assert property (@(posedge clk) disable iff (!rst_b)
    load_r && clk_en |=> trim_r == $past(factory_trim))
    else $error("factory trim not loaded");

  a_load_once: assert property (@(posedge clk) disable iff (!rst_b)
    !load_r |=> !load_r)
    else $error("factory load repeated");

  a_trim_write: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !load_r && wr_trim |=> trim_r == $past(io_req.wdata))
    else $error("trim write not stored");

  a_write_other: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !load_r && !wr_trim |=> $stable(trim_r))
    else $error("trim changed without a write");

  a_range_field: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !load_r && wr_trim |=> osc_trim_value.range == $past(io_req.wdata[FRC_RANGE_MSB:FRC_RANGE_LSB]))
    else $error("range field wrong");

  a_tune_field: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !load_r && wr_trim |=> osc_trim_value.tune == $past(io_req.wdata[FRC_TUNE_MSB:FRC_TUNE_LSB]))
    else $error("tune field wrong");

  a_trim_read: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && rd_trim |=> io_rdata == $past(trim_r))
    else $error("trim read data wrong");

  a_mcu_read: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && rd_mcu |=> io_rdata == $past(mcu_r))
    else $error("control read data wrong");

  a_mcu_reserved: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && rd_mcu |=> (io_rdata & ~FRC_MCU_WMASK) == 8'h00)
    else $error("unused control bits read nonzero");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && io_req.rd && !rd_trim && !rd_mcu |=> io_rdata == 8'h00)
    else $error("unmapped read nonzero");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !io_req.rd |=> io_rdata == 8'h00)
    else $error("read data held too long");

  a_freeze_all: assert property (@(posedge clk) disable iff (!rst_b)
    !clk_en |=> $stable(trim_r) && $stable(mcu_r) && $stable(rdata_r)
      && $stable(div_r) && $stable(load_r))
    else $error("state moved while clock enable low");

  // Clock output checks
  a_ckout_en_bit: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && wr_mcu |=> clk_out_enable == $past(io_req.wdata[FRC_CKOUT_BIT]))
    else $error("clock out enable not written");

  a_ckout_keep: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !wr_mcu |=> $stable(clk_out_enable))
    else $error("clock out enable changed without a write");

  a_clk_divide: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && clk_out_enable && !prog_mode ##1 clk_en && clk_out_enable && !prog_mode
      |-> port_b_bit_two_o != $past(port_b_bit_two_o))
    else $error("clock out not toggling");

  a_pin_from_div: assert property (@(posedge clk) disable iff (!rst_b)
    !prog_mode && clk_out_enable |-> port_b_bit_two_en && port_b_bit_two_o == div_r)
    else $error("divided clock not on pin");

  a_div_held: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && (!clk_out_enable || prog_mode) |=> !div_r)
    else $error("divider not held at zero");

  a_prog_override: assert property (@(posedge clk) disable iff (!rst_b)
    prog_mode |-> port_b_bit_two_o == prog_data_out && port_b_bit_two_en)
    else $error("programming output lost");

  a_port_normal: assert property (@(posedge clk) disable iff (!rst_b)
    !prog_mode && !clk_out_enable |-> port_b_bit_two_o == port_b_bit_two_out
      && port_b_bit_two_en == port_b_bit_two_oe)
    else $error("port function not kept");

  c_trim_write: cover property (@(posedge clk) disable iff (!rst_b)
    wr_trim && clk_en && !load_r);
  c_factory_load: cover property (@(posedge clk) disable iff (!rst_b)
    load_r && clk_en);
  c_clk_out: cover property (@(posedge clk) disable iff (!rst_b)
    clk_out_enable && !prog_mode ##1 clk_out_enable);
  c_freeze: cover property (@(posedge clk) disable iff (!rst_b)
    !clk_en && clk_out_enable);
  c_prog: cover property (@(posedge clk) disable iff (!rst_b)
    prog_mode && clk_out_enable);
endmodule // frc_trim_clkout
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the trim register and divided clock output
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import frc_pkg::*;
  logic clk, rst_b, clk_en, prog_mode, prog_d, pb_out, pb_oe;
  frc_io_req_s io_req;
  logic [7:0] factory_trim, io_rdata;
  frc_trim_s trim;
  logic ck_en, pin_o, pin_en, last;
  logic [7:0] vals [4] = '{8'h1f, 8'h20, 8'h00, 8'hff};
  int num_errors = 0, checks_done = 0, cycles = 0;
  frc_trim_clkout i_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .io_req(io_req),
    .factory_trim(factory_trim), .prog_mode(prog_mode), .prog_data_out(prog_d),
    .port_b_bit_two_out(pb_out), .port_b_bit_two_oe(pb_oe), .io_rdata(io_rdata),
    .osc_trim_value(trim), .clk_out_enable(ck_en), .port_b_bit_two_o(pin_o), .port_b_bit_two_en(pin_en));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Request held for one rising edge; read data sampled the cycle after
  task automatic acc(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    io_req = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clk);
    io_req = '0;
  endtask
  task automatic rdc(input string n, input logic [5:0] a, input logic [7:0] e);
    acc(1'b0, 1'b1, a, 8'h00);
    chk(n, e, io_rdata);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    rst_b = 1'b0; clk_en = 1'b1; io_req = '0; factory_trim = 8'h5a;
    prog_mode = 1'b0; prog_d = 1'b1; pb_out = 1'b1; pb_oe = 1'b0;
    repeat (3) @(negedge clk);
    chk("pre trim", FRC_TRIM_DEFAULT, trim);
    rst_b = 1'b1;
    @(negedge clk);
    chk("factory", 8'h5a, trim);
    rdc("mcu rst", FRC_ADDR_MCU, FRC_MCU_RST);
    chk("ck rst", 8'h00, {7'h00, ck_en});
    $display("reset test done");
    // No nonvolatile writes run here, so codes above the safe point are allowed
    foreach (vals[i]) begin
      acc(1'b1, 1'b0, FRC_ADDR_TRIM, vals[i]);
      chk("range", {5'h00, vals[i][7:5]}, {5'h00, trim.range});
      chk("tune", {3'h0, vals[i][4:0]}, {3'h0, trim.tune});
      rdc("trim rd", FRC_ADDR_TRIM, vals[i]);
    end
    acc(1'b1, 1'b0, 6'h01, 8'h12);
    rdc("unmapped", 6'h01, 8'h00);
    chk("kept", 8'hff, trim);
    $display("trim test done");
    // Mid-run reset must restore the pre-load value and fetch the factory trim again
    @(negedge clk);
    rst_b = 1'b0;
    factory_trim = 8'h3c;
    @(negedge clk);
    chk("rst trim", FRC_TRIM_DEFAULT, trim);
    rst_b = 1'b1;
    @(negedge clk);
    chk("reload", 8'h3c, trim);
    $display("second reset test done");
    acc(1'b1, 1'b0, FRC_ADDR_MCU, 8'hff);
    chk("ck en", 8'h01, {7'h00, ck_en});
    rdc("mcu rd", FRC_ADDR_MCU, 8'h20);
    chk("pin en", 8'h01, {7'h00, pin_en});
    repeat (4) begin
      last = pin_o;
      @(negedge clk);
      chk("div2", {7'h00, ~last}, {7'h00, pin_o});
    end
    clk_en = 1'b0;
    last = pin_o;
    acc(1'b1, 1'b0, FRC_ADDR_TRIM, 8'h11);
    chk("frozen", {7'h00, last}, {7'h00, pin_o});
    chk("frozen trim", 8'h3c, trim);
    clk_en = 1'b1;
    prog_mode = 1'b1;
    @(negedge clk);
    chk("prog 1", 8'h01, {7'h00, pin_o});
    chk("prog en", 8'h01, {7'h00, pin_en});
    prog_d = 1'b0;
    @(negedge clk);
    chk("prog 0", 8'h00, {7'h00, pin_o});
    prog_mode = 1'b0;
    acc(1'b1, 1'b0, FRC_ADDR_MCU, 8'h00);
    chk("port o", 8'h01, {7'h00, pin_o});
    chk("port en", 8'h00, {7'h00, pin_en});
    chk("ck off", 8'h00, {7'h00, ck_en});
    $display("clock out test done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
